//--- core/cbp_branch_unit.sv
// branch unit timing and resource locking for conditional branches
// assumes fetcher, tag completion and condition register on pclk
//
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none

// Behaviour
// - only branches updating count or link pass through writeback
// - writeback waits for tag completion before link/count update
// - tag done before resolution: leave writeback, stay in recovery
// - resolved condition: read condition register in combined dispatch cycle
// - condition register read on last recovery cycle ends recovery
// - link bit: return address into shadow, copied to link at writeback
// - linking branch holds one of two shadows, dispatch to writeback+1
// - target fetch arbitration in dispatch/execute cycle only when taken
// - branch to link uses newest pending shadow link value
// - branch to count forwards pending decremented count values
// - decrement: count read at dispatch, written only at writeback
// - at most one unresolved predicted branch; others stall
module cbp_branch_unit
  import cbp_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic [DATA_W-1:0]        prdata,
  output logic                     pready,
  output logic                     pslverr,
  // branch request from fetcher
  input  wire logic                br_valid,
  input  wire logic [1:0]          br_target_kind,
  input  wire logic                br_link_bit,
  input  wire logic                br_dec_ctr,
  input  wire logic                br_ctr_zero_sense,
  input  wire logic                br_cond_dep,
  input  wire logic [CR_SEL_W-1:0] br_cr_sel,
  input  wire logic                br_cr_sense,
  input  wire logic                br_pred_taken,
  input  wire logic [DATA_W-1:0]   br_ret_addr,
  input  wire logic [DATA_W-1:0]   br_imm_target,
  output logic                     br_ready,
  // integer pipeline and condition register
  input  wire logic                tag_done,
  input  wire logic                cr_resolved,
  input  wire logic [DATA_W-1:0]   condition_register,
  // fetch and recovery
  output logic                     fetch_req,
  output logic [DATA_W-1:0]        fetch_addr,
  output logic                     mispredict,
  output logic [DATA_W-1:0]        recovery_addr,
  // stage and architected state
  output logic [FRONT_STAGES-1:0]  front_stage,
  output logic                     mispredict_recovery_stage,
  output logic                     branch_writeback_stage,
  output logic [DATA_W-1:0]        link_register,
  output logic [DATA_W-1:0]        count_register
);

  // ********************************
  // state
  // ********************************
  logic              en_q, en_d, ready_q, ready_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              pready_q, pready_d, perr_q, perr_d;
  cbp_tgt_t          kind_q, kind_d;
  logic              link_q, link_d, dec_q, dec_d, zs_q, zs_d, cond_q, cond_d;
  logic [CR_SEL_W-1:0] sel_q, sel_d;
  logic              sense_q, sense_d, pred_q, pred_d;
  logic [DATA_W-1:0] ret_q, ret_d, imm_q, imm_d;
  cbp_mr_t           mr_q, mr_d;
  logic              mr_pred_q, mr_pred_d;
  logic [CR_SEL_W-1:0] mr_sel_q, mr_sel_d;
  logic              mr_sense_q, mr_sense_d, mr_ctr_ok_q, mr_ctr_ok_d;
  logic [DATA_W-1:0] mr_alt_q, mr_alt_d;
  logic              freq_q, freq_d, misp_q, misp_d, wb_q, wb_d;
  logic [DATA_W-1:0] faddr_q, faddr_d, raddr_q, raddr_d;
  logic [DATA_W-1:0] lr_q, lr_d, ctr_q, ctr_d;
  logic              old_q, old_d;
  logic [FRONT_STAGES-1:0] stage_q;

  // ********************************
  // combinational helpers
  // ********************************
  logic              accept, dx, alloc, alloc_sel, retire, need_wb;
  logic              taken, ctr_ok, cr_ok, cr_bit;
  logic [DATA_W-1:0] la_lr, la_ctr, new_ctr, tgt;
  logic [1:0]        s_valid, s_busy, s_link, s_dec, s_alloc, s_retire;
  logic [DATA_W-1:0] s_lr [2];
  logic [DATA_W-1:0] s_ctr [2];

  assign accept = br_valid & ready_q;
  assign dx     = stage_q[FRONT_STAGES-1];

  // ********************************
  // front stages and shadow slots
  // ********************************
  cbp_front_pipe #(.STAGES(FRONT_STAGES)) u_front (
    .pclk    (pclk),
    .presetn (presetn),
    .enter   (accept),
    .stage_q (stage_q)
  );

  for (genvar i = 0; i < 2; i++) begin : g_slot
    cbp_shadow_slot #(.W(DATA_W)) u_slot (
      .pclk       (pclk),
      .presetn    (presetn),
      .alloc      (s_alloc[i]),
      .alloc_link (link_q),
      .alloc_dec  (dec_q),
      .alloc_lr   (ret_q),
      .alloc_ctr  (new_ctr),
      .retire     (s_retire[i]),
      .valid_q    (s_valid[i]),
      .busy       (s_busy[i]),
      .link_q     (s_link[i]),
      .dec_q      (s_dec[i]),
      .lr_q       (s_lr[i]),
      .ctr_q      (s_ctr[i])
    );
  end

  // ********************************
  // look-ahead, condition and dispatch
  // ********************************
  always_comb begin
    la_lr = lr_q;
    if (s_valid[old_q] && s_link[old_q]) la_lr = s_lr[old_q];
    if (s_valid[~old_q] && s_link[~old_q]) la_lr = s_lr[~old_q];
    la_ctr = ctr_q;
    if (s_valid[old_q] && s_dec[old_q]) la_ctr = s_ctr[old_q];
    if (s_valid[~old_q] && s_dec[~old_q]) la_ctr = s_ctr[~old_q];
    new_ctr = dec_q ? la_ctr - 32'h0000_0001 : la_ctr;
    ctr_ok  = !dec_q || ((new_ctr != 32'h0000_0000) ^ zs_q);
    cr_bit  = condition_register[sel_q];
    cr_ok   = !cond_q || (cr_bit == sense_q);
    case (kind_q)
      TGT_LINK:  tgt = la_lr & TGT_MASK;
      TGT_COUNT: tgt = la_ctr & TGT_MASK;
      default:   tgt = imm_q;
    endcase
    taken     = (cond_q && !cr_resolved) ? pred_q : (ctr_ok && cr_ok);
    need_wb   = link_q | dec_q;
    alloc     = dx & need_wb;
    alloc_sel = s_busy[0];
    s_alloc   = alloc ? (alloc_sel ? 2'b10 : 2'b01) : 2'b00;
    retire    = tag_done & s_valid[old_q];
    s_retire  = retire ? (old_q ? 2'b10 : 2'b01) : 2'b00;
  end

  // ********************************
  // branch sequencing
  // ********************************
  always_comb begin
    kind_d = kind_q; link_d = link_q; dec_d = dec_q; zs_d = zs_q;
    cond_d = cond_q; sel_d = sel_q; sense_d = sense_q; pred_d = pred_q;
    ret_d = ret_q; imm_d = imm_q;
    mr_d = mr_q; mr_pred_d = mr_pred_q; mr_sel_d = mr_sel_q;
    mr_sense_d = mr_sense_q; mr_ctr_ok_d = mr_ctr_ok_q;
    mr_alt_d = mr_alt_q;
    freq_d = 1'b0; faddr_d = faddr_q; misp_d = 1'b0; raddr_d = raddr_q;
    wb_d = retire; lr_d = lr_q; ctr_d = ctr_q; old_d = old_q;
    if (accept) begin
      kind_d = cbp_tgt_t'(br_target_kind); link_d = br_link_bit;
      dec_d = br_dec_ctr; zs_d = br_ctr_zero_sense; cond_d = br_cond_dep;
      sel_d = br_cr_sel; sense_d = br_cr_sense; pred_d = br_pred_taken;
      ret_d = br_ret_addr; imm_d = br_imm_target;
    end
    if (dx) begin
      if (taken) begin
        freq_d  = 1'b1;
        faddr_d = tgt;
      end
      if (cond_q && !cr_resolved) begin
        mr_d        = MR_WAIT;
        mr_pred_d   = pred_q;
        mr_sel_d    = sel_q;
        mr_sense_d  = sense_q;
        mr_ctr_ok_d = ctr_ok;
        mr_alt_d    = pred_q ? ret_q : tgt;
      end
    end
    case (mr_q)
      MR_WAIT: begin
        if (cr_resolved) begin
          mr_d = MR_IDLE;
          if ((mr_ctr_ok_q && (condition_register[mr_sel_q] == mr_sense_q))
              != mr_pred_q) begin
            misp_d  = 1'b1;
            raddr_d = mr_alt_q;
          end
        end
      end
      default: mr_d = mr_d;
    endcase
    if (retire) begin
      if (s_link[old_q]) lr_d = s_lr[old_q];
      if (s_dec[old_q]) ctr_d = s_ctr[old_q];
      old_d = ~old_q;
    end else if (alloc && !s_valid[0] && !s_valid[1]) begin
      old_d = alloc_sel;
    end
  end

  // ********************************
  // apb slave and readiness
  // ********************************
  always_comb begin
    en_d = en_q; rdata_d = rdata_q; pready_d = 1'b0; perr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      case (paddr)
        CTRL_OFS:   rdata_d[CTRL_EN_BIT] = en_q;
        STATUS_OFS: begin
          rdata_d[ST_MR_BIT]    = (mr_q == MR_WAIT);
          rdata_d[ST_SLOT0_BIT] = s_busy[0];
          rdata_d[ST_SLOT1_BIT] = s_busy[1];
          rdata_d[ST_FRONT_LSB +: FRONT_STAGES] = stage_q;
        end
        LINK_OFS:   rdata_d = lr_q;
        COUNT_OFS:  rdata_d = ctr_q;
        default:    perr_d = 1'b1;
      endcase
    end
    if (psel && penable && pready_q && pwrite && paddr == CTRL_OFS) begin
      en_d = pwdata[CTRL_EN_BIT];
    end
    ready_d = en_q && !accept && !(|stage_q[FRONT_STAGES-2:0])
              && (mr_d == MR_IDLE)
              && ((!s_busy[0] && !s_alloc[0]) || (!s_busy[1] && !s_alloc[1]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= CTRL_EN_RST; ready_q <= 1'b0; rdata_q <= '0;
      pready_q <= 1'b0; perr_q <= 1'b0;
      kind_q <= TGT_IMM; link_q <= 1'b0; dec_q <= 1'b0; zs_q <= 1'b0;
      cond_q <= 1'b0; sel_q <= '0; sense_q <= 1'b0; pred_q <= 1'b0;
      ret_q <= '0; imm_q <= '0;
      mr_q <= MR_IDLE; mr_pred_q <= 1'b0; mr_sel_q <= '0; mr_sense_q <= 1'b0;
      mr_ctr_ok_q <= 1'b0; mr_alt_q <= '0;
      freq_q <= 1'b0; faddr_q <= '0; misp_q <= 1'b0; raddr_q <= '0;
      wb_q <= 1'b0; lr_q <= LINK_RST; ctr_q <= COUNT_RST; old_q <= 1'b0;
    end else begin
      en_q <= en_d; ready_q <= ready_d; rdata_q <= rdata_d;
      pready_q <= pready_d; perr_q <= perr_d;
      kind_q <= kind_d; link_q <= link_d; dec_q <= dec_d; zs_q <= zs_d;
      cond_q <= cond_d; sel_q <= sel_d; sense_q <= sense_d; pred_q <= pred_d;
      ret_q <= ret_d; imm_q <= imm_d;
      mr_q <= mr_d; mr_pred_q <= mr_pred_d; mr_sel_q <= mr_sel_d;
      mr_sense_q <= mr_sense_d; mr_ctr_ok_q <= mr_ctr_ok_d;
      mr_alt_q <= mr_alt_d;
      freq_q <= freq_d; faddr_q <= faddr_d; misp_q <= misp_d; raddr_q <= raddr_d;
      wb_q <= wb_d; lr_q <= lr_d; ctr_q <= ctr_d; old_q <= old_d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign prdata                    = rdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = perr_q;
  assign br_ready                  = ready_q;
  assign fetch_req                 = freq_q;
  assign fetch_addr                = faddr_q;
  assign mispredict                = misp_q;
  assign recovery_addr             = raddr_q;
  assign front_stage               = stage_q;
  assign mispredict_recovery_stage = (mr_q == MR_WAIT);
  assign branch_writeback_stage    = wb_q;
  assign link_register             = lr_q;
  assign count_register            = ctr_q;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wb_only_needed_a: assert property (alloc |-> (link_q || dec_q))
    else $error("writeback entry for branch without link or count update");
  lr_on_tag_a: assert property (lr_q != $past(lr_q) |-> $past(tag_done))
    else $error("link register changed without tag completion");
  bw_before_mr_a: assert property (
    (mr_q == MR_WAIT) && !cr_resolved && retire |=> wb_q && (mr_q == MR_WAIT))
    else $error("early tag completion did not leave recovery busy");
  k_zero_a: assert property (dx && cr_resolved |=> mr_q == MR_IDLE)
    else $error("resolved condition still entered recovery wait");
  mr_end_a: assert property ((mr_q == MR_WAIT) && cr_resolved |=> mr_q == MR_IDLE)
    else $error("condition read did not end recovery");
  lr_copy_a: assert property (retire && s_link[old_q] |=> lr_q == $past(s_lr[old_q]))
    else $error("shadow link not copied at writeback");
  shadow_free_a: assert property (
    retire |=> s_busy[$past(old_q)] ##1 !s_busy[$past(old_q, 2)] || s_alloc != 2'b00)
    else $error("shadow not held one cycle past writeback");
  fetch_taken_a: assert property (freq_q |-> $past(dx))
    else $error("target fetch outside dispatch cycle");
  la_link_a: assert property (
    dx && taken && kind_q == TGT_LINK && s_valid[~old_q] && s_link[~old_q]
    |=> fetch_addr == ($past(s_lr[~old_q]) & TGT_MASK))
    else $error("link target ignored newest shadow");
  la_count_a: assert property (
    dx && taken && kind_q == TGT_COUNT && s_valid[~old_q] && s_dec[~old_q]
    |=> fetch_addr == ($past(s_ctr[~old_q]) & TGT_MASK))
    else $error("count target ignored pending decrement");
  ctr_lock_a: assert property (ctr_q != $past(ctr_q) |-> $past(retire))
    else $error("count register written outside writeback");
  one_pred_a: assert property ((mr_q == MR_WAIT) |-> !ready_q)
    else $error("branch accepted while prediction unresolved");
  front_time_a: assert property (
    accept |=> stage_q[0] ##1 stage_q[1] ##1 stage_q[2] ##1 !(|stage_q))
    else $error("front stages not one cycle each");

  cov_mispredict_c: cover property (dx && cond_q && !cr_resolved ##[1:20] misp_q);
  cov_two_shadows_c: cover property (s_valid == 2'b11);
  cov_wb_in_mr_c: cover property ((mr_q == MR_WAIT) && wb_q);

endmodule : cbp_branch_unit

`default_nettype wire

//--- inc/cbp_pkg.sv
// conditional-branch pipeline timing: shared constants and types
// assumes a single core clock and 32-bit apb register access
`default_nettype none

package cbp_pkg;

  // ********************************
  // widths and structure
  // ********************************
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned CR_SEL_W     = 5;
  localparam int unsigned FRONT_STAGES = 3;   // fetch arb, cache access, dispatch/exec/predict

  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LINK_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h0c;

  // ********************************
  // fields and reset values
  // ********************************
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned ST_MR_BIT    = 0;
  localparam int unsigned ST_SLOT0_BIT = 1;
  localparam int unsigned ST_SLOT1_BIT = 2;
  localparam int unsigned ST_FRONT_LSB = 3;
  localparam logic              CTRL_EN_RST = 1'b1;
  localparam logic [DATA_W-1:0] LINK_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TGT_MASK    = 32'hffff_fffc;

  // ********************************
  // types
  // ********************************
  typedef enum logic [1:0] {
    TGT_IMM,
    TGT_LINK,
    TGT_COUNT
  } cbp_tgt_t;

  typedef enum logic {
    MR_IDLE,
    MR_WAIT
  } cbp_mr_t;

endpackage : cbp_pkg

`default_nettype wire

//--- core/cbp_front_pipe.sv
// one-hot walk of a branch through the fixed front stages
// assumes at most one branch enters while the pipe is empty
`default_nettype none

module cbp_front_pipe
  import cbp_pkg::*;
#(
  parameter int unsigned STAGES = FRONT_STAGES
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // control
  input  wire logic              enter,
  // stage occupancy
  output logic [STAGES-1:0]      stage_q
);

  logic [STAGES-1:0] stage_d;

  // ********************************
  // one cycle per stage
  // ********************************
  always_comb begin
    stage_d = {stage_q[STAGES-2:0], enter};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

endmodule : cbp_front_pipe

`default_nettype wire

//--- core/cbp_shadow_slot.sv
// one link shadow / writeback entry awaiting tag completion
// assumes alloc only when not busy and retire only when valid
`default_nettype none

module cbp_shadow_slot
  import cbp_pkg::*;
#(
  parameter int unsigned W = DATA_W
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // fill and drain
  input  wire logic          alloc,
  input  wire logic          alloc_link,
  input  wire logic          alloc_dec,
  input  wire logic [W-1:0]  alloc_lr,
  input  wire logic [W-1:0]  alloc_ctr,
  input  wire logic          retire,
  // state
  output logic               valid_q,
  output logic               busy,
  output logic               link_q,
  output logic               dec_q,
  output logic [W-1:0]       lr_q,
  output logic [W-1:0]       ctr_q
);

  logic         valid_d;
  logic         rel_q;
  logic         rel_d;
  logic         link_d;
  logic         dec_d;
  logic [W-1:0] lr_d;
  logic [W-1:0] ctr_d;

  // ********************************
  // hold from dispatch to one cycle past writeback
  // ********************************
  always_comb begin
    valid_d = valid_q;
    rel_d   = 1'b0;
    link_d  = link_q;
    dec_d   = dec_q;
    lr_d    = lr_q;
    ctr_d   = ctr_q;
    if (alloc) begin
      valid_d = 1'b1;
      link_d  = alloc_link;
      dec_d   = alloc_dec;
      lr_d    = alloc_lr;
      ctr_d   = alloc_ctr;
    end else if (retire) begin
      valid_d = 1'b0;
      rel_d   = 1'b1;
    end
  end

  assign busy = valid_q | rel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      rel_q   <= 1'b0;
      link_q  <= 1'b0;
      dec_q   <= 1'b0;
      lr_q    <= '0;
      ctr_q   <= '0;
    end else begin
      valid_q <= valid_d;
      rel_q   <= rel_d;
      link_q  <= link_d;
      dec_q   <= dec_d;
      lr_q    <= lr_d;
      ctr_q   <= ctr_d;
    end
  end

endmodule : cbp_shadow_slot

`default_nettype wire

//--- test/cbp_far_model.sv
// far side: integer pipeline tag completion and condition resolution
// assumes bench kicks on pclk, one outstanding kick of each kind
`default_nettype none

module cbp_far_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // commands
  input  wire logic       tag_kick,
  input  wire logic [7:0] tag_wait,
  input  wire logic       cr_kick,
  input  wire logic [7:0] cr_wait,
  // answers
  output logic            tag_done,
  output logic            cr_resolved
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // countdowns
  // ********************************
  logic [7:0] tag_cnt_q;
  logic [7:0] cr_cnt_q;
  // condition stays incoherent while counting
  assign cr_resolved = (cr_cnt_q == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_cnt_q <= 8'h00;
      cr_cnt_q  <= 8'h00;
      tag_done  <= 1'b0;
    end else begin
      tag_cnt_q <= tag_kick ? tag_wait : (tag_cnt_q != 8'h00 ? tag_cnt_q - 8'h01 : 8'h00);
      cr_cnt_q  <= cr_kick ? cr_wait : (cr_cnt_q != 8'h00 ? cr_cnt_q - 8'h01 : 8'h00);
      tag_done  <= (tag_cnt_q == 8'h01) && !tag_kick;
    end
  end
endmodule : cbp_far_model

`default_nettype wire

//--- test/cbp_branch_unit_tb_top.sv
// bench: branch unit against a queue model of pending writebacks
// assumes far model for tag completion and condition resolution
`default_nettype none

module cbp_branch_unit_tb_top import cbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // signals and model state
  // ********************************
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, tag_wait = 8'h00, cr_wait = 8'h00;
  logic [31:0] pwdata = 32'h0, condition_register = 32'h0, br_ret_addr = 32'h0;
  logic [31:0] br_imm_target = 32'h0, prdata, fetch_addr, recovery_addr;
  logic [31:0] link_register, count_register, la_lr = 32'h0, la_ctr = 32'h0;
  logic [31:0] a_lr = 32'h0, a_ctr = 32'h0, last_ra = 32'h0, last_im = 32'h0;
  logic [1:0]  br_target_kind = 2'h0;
  logic [CR_SEL_W-1:0] br_cr_sel = '0;
  logic [FRONT_STAGES-1:0] front_stage;
  logic        br_valid = 1'b0, br_link_bit = 1'b0, br_dec_ctr = 1'b0, br_ctr_zero_sense = 1'b0;
  logic        br_cond_dep = 1'b0, br_cr_sense = 1'b0, br_pred_taken = 1'b0, tag_kick = 1'b0;
  logic        cr_kick = 1'b0, pready, pslverr, br_ready, fetch_req, mispredict;
  logic        mispredict_recovery_stage, branch_writeback_stage, tag_done, cr_resolved;
  logic [65:0] q[$];
  int          fails = 0, checks_done = 0, cyc = 0;

  cbp_branch_unit u_cbp_branch_unit (.*);
  cbp_far_model u_cbp_far_model (.*);

  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      results();
    end
  end

  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task br(input logic [1:0] kd, input logic lk, dc, zs, cd, sn, pt, input int ck);
    logic [31:0] tg, im;
    logic ok, fe;
    @(posedge pclk);
    last_ra = $urandom;
    im = $urandom;
    last_im = im;
    br_valid <= 1'b1;
    br_target_kind <= kd;
    br_link_bit <= lk;
    br_dec_ctr <= dc;
    br_ctr_zero_sense <= zs;
    br_cond_dep <= cd;
    br_cr_sense <= sn;
    br_pred_taken <= pt;
    br_ret_addr <= last_ra;
    br_imm_target <= im;
    cr_wait <= ck[7:0];
    cr_kick <= (ck > 0);
    @(posedge pclk);
    cr_kick <= 1'b0;
    while (!br_ready) @(posedge pclk);
    br_valid <= 1'b0;
    tg = kd == 2'd1 ? la_lr & TGT_MASK : (kd == 2'd2 ? la_ctr & TGT_MASK : im);
    if (dc) la_ctr = la_ctr - 1;
    ok = !dc || (zs ? la_ctr == 0 : la_ctr != 0);
    fe = (cd && ck > 0) ? pt : (ok && (!cd || condition_register[0] == sn));
    if (lk || dc) q.push_back({lk, dc, last_ra, la_ctr});
    if (lk) la_lr = last_ra;
    for (int i = 0; i < 3; i++) begin
      #1 chk(front_stage, 3'b001 << i, "front");
      @(posedge pclk);
    end
    #1 chk(fetch_req, fe, "fetch");
    if (fe) chk(fetch_addr, tg, "target");
    chk(mispredict_recovery_stage, cd && ck > 0, "recovery");
  endtask : br

  task wb(input int n);
    logic [65:0] e;
    @(posedge pclk);
    tag_wait <= n[7:0];
    tag_kick <= 1'b1;
    @(posedge pclk);
    tag_kick <= 1'b0;
    #1 chk(link_register, a_lr, "early");
    while (tag_done !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    e = q.pop_front();
    if (e[65]) a_lr = e[63:32];
    if (e[64]) a_ctr = e[31:0];
    @(posedge pclk);
    #1 chk(branch_writeback_stage, 1, "wb");
    chk(link_register, a_lr, "lr");
    chk(count_register, a_ctr, "ctr");
  endtask : wb

  // ********************************
  // sequence
  // ********************************
  initial begin
    logic [31:0] r;
    logic e;
    void'($urandom(99));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, CTRL_OFS, 0, r, e);
    chk(r, {31'h0, CTRL_EN_RST}, "ctrl");
    apb(0, STATUS_OFS, 0, r, e);
    chk(r, 0, "status");
    apb(1, LINK_OFS, 32'hdeadbeef, r, e);
    apb(0, LINK_OFS, 0, r, e);
    chk(r, LINK_RST, "link ro");
    apb(0, 8'h10, 0, r, e);
    chk(r, 0, "unmapped data");
    chk(e, 1, "unmapped error");
    apb(1, CTRL_OFS, 0, r, e);
    repeat (2) @(posedge pclk);
    #1 chk(br_ready, 0, "disabled");
    apb(1, CTRL_OFS, 1, r, e);
    $display("test regs done");
    br(0, 1, 0, 0, 0, 0, 0, 0);
    br(1, 1, 0, 0, 0, 0, 0, 0);
    chk(br_ready, 0, "slots full");
    wb(3);
    wb(1);
    $display("test link done");
    br(0, 0, 1, 0, 0, 0, 0, 0);
    chk(count_register, a_ctr, "ctr held");
    br(2, 0, 0, 0, 0, 0, 0, 0);
    wb(2);
    br(0, 0, 1, 1, 0, 0, 0, 0);
    wb(1);
    br(0, 0, 0, 0, 0, 0, 0, 0);
    apb(0, STATUS_OFS, 0, r, e);
    chk(r, 0, "no entry");
    $display("test count done");
    for (int s = 0; s < 2; s++) begin
      @(posedge pclk);
      condition_register <= {31'($urandom), s[0]};
      br(0, 0, 0, 0, 1, s[0], 0, 0);
      br(0, 0, 0, 0, 1, !s[0], 1, 0);
    end
    $display("test resolved done");
    @(posedge pclk);
    condition_register <= 32'h0;
    br(0, 1, 0, 0, 1, 1, 1, 16);
    chk(br_ready, 0, "one predicted");
    wb(2);
    chk(mispredict_recovery_stage, 1, "still waiting");
    while (!cr_resolved) begin
      @(posedge pclk);
      #1;
    end
    @(posedge pclk);
    #1 chk(mispredict_recovery_stage, 0, "resolved");
    chk(mispredict, 1, "mispredict");
    chk(recovery_addr, last_ra, "recovery addr");
    @(posedge pclk);
    condition_register <= 32'h1;
    br(0, 0, 0, 0, 1, 1, 0, 5);
    while (!cr_resolved) begin
      @(posedge pclk);
      #1;
    end
    @(posedge pclk);
    #1 chk(mispredict, 1, "late taken");
    chk(recovery_addr, last_im, "recovery target");
    $display("test predicted done");
    results();
  end
endmodule : cbp_branch_unit_tb_top

`default_nettype wire
